//--- core/rsc_regs.svh
// Constants for the reset strap sampler: field positions, reset values, counts.
// Assumes inclusion by the strap sampler package users only.
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_IDENT_W 12
`define RSC_REV_W 4
`define RSC_IDENT_VAL 12'h5A5
`define RSC_REV_VAL 4'h1
`define RSC_STATUS_RST 6'h00
`define RSC_AC_LO 0
`define RSC_AC_HI 2
`define RSC_IF_LO 3
`define RSC_IF_HI 4
`define RSC_TEST_BIT 5
`define RSC_AC_NO_AUTO 3'h3
`define RSC_AC_NVM_PROG 3'h0
`define RSC_IF_I2C_A0 2'h0
`define RSC_IF_I2C_A1 2'h1
`define RSC_IF_SPI_SLV 2'h2
`define RSC_IF_SPI_MST 2'h3
`define RSC_I2C_ADDR_BASE 5'h1D
`define RSC_EE_CYCLES 8'h40
`endif

//--- core/rsc_pkg.sv
// Types shared by the strap sampler.
// Assumes rsc_regs.svh for numeric constants.
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_IF_I2C = 2'h0,
        RSC_IF_SPI_SLAVE = 2'h1,
        RSC_IF_SPI_MASTER = 2'h3
    } rsc_if_mode_t;
    typedef struct packed {
        logic test;
        logic [1:0] iface;
        logic [2:0] config_sel;
    } rsc_straps_t;
    typedef struct packed {
        logic oe_n;
        logic out;
    } rsc_pin_drv_t;
endpackage : rsc_pkg

//--- core/rsc_ident.sv
// Read-only identification and revision fields split over two registers.
// Assumes nothing of its surroundings; values are constants.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_regs.svh"
module rsc_ident
    import rsc_pkg::*;
(
    output logic [7:0] ident_reg_high,
    output logic [7:0] ident_reg_low
);
    // Identity value is arbitrary
    localparam logic [15:0] IDENT_WORD = {`RSC_IDENT_VAL, `RSC_REV_VAL};
    assign ident_reg_high = IDENT_WORD[15:8];
    assign ident_reg_low = IDENT_WORD[7:0];
endmodule : rsc_ident
`default_nettype wire

//--- core/rsc_sampler.sv
// Strap sampler: catches straps on reset pin rise, decodes modes, hands pins over.
// Assumes pins already synchronous to clock; resetn is the core reset.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_regs.svh"
module rsc_sampler
    import rsc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic reset_pin_low,
    input wire logic internal_nvm,
    input wire logic [2:0] config_select_straps,
    input wire logic test_strap,
    input wire logic [1:0] iface_straps,
    input wire logic autocfg_mosi,
    input wire logic autocfg_done,
    input wire logic [3:0] general_io_out,
    input wire logic [3:0] general_io_oe_n,
    output logic [3:0] general_io_pin_out,
    output logic [3:0] general_io_pin_oe_n,
    output logic spi_select_low_out,
    output logic spi_select_low_oe_n,
    output logic mosi_out,
    output logic mosi_oe_n,
    output logic [5:0] strap_capture_status,
    output logic [7:0] ident_reg_high,
    output logic [7:0] ident_reg_low,
    output logic [2:0] config_number,
    output logic autocfg_enable,
    output logic test_mode,
    output logic [2:0] test_mode_sel,
    output logic nvm_program_mode,
    output logic [1:0] if_mode,
    output logic [6:0] i2c_addr_setting,
    output logic autocfg_busy
);
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_AUTOCFG = 2'b01,
        ST_NORMAL = 2'b11
    } rsc_state_t;

    rsc_state_t state_reg;
    rsc_state_t state_next;

    logic pin_prev_reg;
    logic pin_prev_next;
    logic [5:0] status_reg;
    logic [5:0] status_next;
    rsc_straps_t straps_now;
    rsc_straps_t straps_cap;

    logic rise;
    logic pin_held_low;
    logic in_reset;
    logic in_autocfg;
    logic master_boot;
    logic abort_boot;
    logic boot_finish;
    logic [1:0] addr_lsb;

    rsc_pin_drv_t sel_drv;
    rsc_pin_drv_t mosi_drv;

    // Interface decode, shared by mode and address logic
    function automatic logic [1:0] if_decode(input logic [1:0] ifs, input logic nvm);
        if_decode = RSC_IF_I2C;
        if (nvm) begin
            if (ifs == `RSC_IF_SPI_MST) begin
                if_decode = RSC_IF_SPI_SLAVE;
            end
        end else begin
            case (ifs)
                `RSC_IF_SPI_SLV: begin
                    if_decode = RSC_IF_SPI_SLAVE;
                end
                `RSC_IF_SPI_MST: begin
                    if_decode = RSC_IF_SPI_MASTER;
                end
                default: begin
                    if_decode = RSC_IF_I2C;
                end
            endcase
        end
    endfunction : if_decode

    // Only external-memory parts boot as master, never in test mode
    function automatic logic boots_as_master(input rsc_straps_t st, input logic nvm);
        boots_as_master = !st.test && !nvm && (st.iface == `RSC_IF_SPI_MST);
    endfunction : boots_as_master

    function automatic logic is_nvm_prog(input rsc_straps_t st, input logic nvm);
        is_nvm_prog = nvm && st.test
            && (st.config_sel == `RSC_AC_NVM_PROG)
            && (st.iface == `RSC_IF_SPI_MST);
    endfunction : is_nvm_prog

    // SPI modes leave the spare address bits at zero
    function automatic logic [1:0] addr_lsb_of(input logic [1:0] mode, input logic [1:0] ifs);
        if (mode == RSC_IF_I2C) begin
            addr_lsb_of = ifs;
        end else begin
            addr_lsb_of = 2'h0;
        end
    endfunction : addr_lsb_of

    rsc_ident u_ident (
        .ident_reg_high(ident_reg_high),
        .ident_reg_low(ident_reg_low)
    );

    assign straps_now = '{test: test_strap, iface: iface_straps,
                          config_sel: config_select_straps};
    // Pin level assumed stable: resetn covers minimum low time
    assign rise = reset_pin_low & ~pin_prev_reg;
    assign pin_held_low = ~reset_pin_low;
    assign straps_cap = status_reg;
    assign pin_prev_next = reset_pin_low;
    // Pin already high at core reset release counts as a power-on sample
    assign status_next = rise ? straps_now : status_reg;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_prev_reg <= 1'b0;
            status_reg <= `RSC_STATUS_RST;
        end else begin
            pin_prev_reg <= pin_prev_next;
            status_reg <= status_next;
        end
    end

    assign in_reset = (state_reg == ST_RESET);
    assign in_autocfg = (state_reg == ST_AUTOCFG);
    assign master_boot = boots_as_master(straps_now, internal_nvm);
    // A new reset pulse abandons a boot read half done
    assign abort_boot = pin_held_low;
    assign boot_finish = autocfg_done;

    assign strap_capture_status = status_reg;
    assign test_mode = straps_cap.test;
    assign test_mode_sel = straps_cap.test ? straps_cap.config_sel : 3'h0;
    assign nvm_program_mode = is_nvm_prog(straps_cap, internal_nvm);
    assign config_number = straps_cap.config_sel;
    // Any test mode keeps the engine idle; config 011 without test mode does not
    assign autocfg_enable = ~straps_cap.test;
    assign if_mode = if_decode(straps_cap.iface, internal_nvm);
    assign addr_lsb = addr_lsb_of(if_mode, straps_cap.iface);
    assign i2c_addr_setting = {`RSC_I2C_ADDR_BASE, addr_lsb};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (rise) begin
                    state_next = master_boot ? ST_AUTOCFG : ST_NORMAL;
                end
            end
            ST_AUTOCFG: begin
                if (abort_boot) begin
                    state_next = ST_RESET;
                end else if (boot_finish) begin
                    state_next = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (pin_held_low) begin
                    state_next = ST_RESET;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign autocfg_busy = in_autocfg;

    // Straps stay undriven while sampling so board resistors set the level
    assign general_io_pin_out = in_reset ? 4'h0 : general_io_out;
    assign general_io_pin_oe_n = in_reset ? 4'hF : general_io_oe_n;
    // Select released outside the boot read; board pull-up idles it
    assign sel_drv = '{oe_n: ~in_autocfg, out: 1'b0};
    // MOSI is an input in slave mode; external master drives it
    assign mosi_drv = '{oe_n: ~in_autocfg,
                        out: in_autocfg ? autocfg_mosi : 1'b1};
    assign spi_select_low_out = sel_drv.out;
    assign spi_select_low_oe_n = sel_drv.oe_n;
    assign mosi_out = mosi_drv.out;
    assign mosi_oe_n = mosi_drv.oe_n;
endmodule : rsc_sampler
`default_nettype wire

//--- testbench/rsc_board.sv
// Board model: strap resistors on the six strap pins.
// Assumes the sampler's pin drives; a driven pin overrides its resistor.
`timescale 1ns/10ps
`default_nettype none
module rsc_board
    import rsc_pkg::*;
(
    input wire rsc_straps_t strap_res,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe_n,
    input wire logic sel_out,
    input wire logic sel_oe_n,
    output rsc_straps_t pins
);
    // Read-data line is never driven here, so it always shows its resistor
    wire logic [5:0] drv_n = {gpio_oe_n[3], 1'b1, sel_oe_n, gpio_oe_n[2:0]};
    wire logic [5:0] drv = {gpio_out[3], 1'b0, sel_out, gpio_out[2:0]};
    assign pins = (strap_res & drv_n) | (drv & ~drv_n);
endmodule : rsc_board
`default_nettype wire

//--- testbench/rsc_sampler_checker.sv
// Port assertions for the strap sampler.
// Assumes bind onto rsc_sampler, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module rsc_checker
    import rsc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic reset_pin_low,
    input wire logic internal_nvm,
    input wire logic [2:0] config_select_straps,
    input wire logic test_strap,
    input wire logic [1:0] iface_straps,
    input wire logic autocfg_done,
    input wire logic spi_select_low_oe_n,
    input wire logic [5:0] strap_capture_status,
    input wire logic [2:0] config_number,
    input wire logic autocfg_enable,
    input wire logic [1:0] if_mode,
    input wire logic [6:0] i2c_addr_setting,
    input wire logic autocfg_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic [5:0] pins = {test_strap, iface_straps, config_select_straps};
    wire logic [1:0] ifs = strap_capture_status[4:3];
    sequence s_rise; $rose(reset_pin_low); endsequence
    sequence s_mst; s_rise ##0 (!test_strap && !internal_nvm && iface_straps == 2'h3); endsequence
    property p_cap; s_rise |=> strap_capture_status == $past(pins); endproperty
    a_cap: assert property (p_cap) else $error("status not captured");
    property p_hold; !$rose(reset_pin_low) |=> $stable(strap_capture_status); endproperty
    a_hold: assert property (p_hold) else $error("status changed");
    property p_cfg; s_rise |=> config_number == $past(config_select_straps); endproperty
    a_cfg: assert property (p_cfg) else $error("config number");
    property p_auto; autocfg_enable == !strap_capture_status[5]; endproperty
    a_auto: assert property (p_auto) else $error("autocfg enable");
    property p_if; if_mode == (internal_nvm ? {1'b0, &ifs} : {&ifs, ifs[1]}); endproperty
    a_if: assert property (p_if) else $error("interface mode");
    property p_i2c; if_mode == 2'h0 |-> i2c_addr_setting == {5'h1D, ifs}; endproperty
    a_i2c: assert property (p_i2c) else $error("i2c address");
    property p_mst; s_mst |=> autocfg_busy && !spi_select_low_oe_n; endproperty
    a_mst: assert property (p_mst) else $error("master start");
    property p_end; autocfg_busy && autocfg_done |=> !autocfg_busy && spi_select_low_oe_n; endproperty
    a_end: assert property (p_end) else $error("select not released");
endmodule : rsc_checker
bind rsc_sampler rsc_checker chk (.*);
`default_nettype wire

//--- testbench/rsc_sampler_bench.sv
// Random strap bench for the strap sampler.
// Assumes rsc_board as strap resistors and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "rsc_regs.svh"
module rsc_sampler_bench;
    import rsc_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, reset_pin_low = 1'b0, internal_nvm = 1'b0, test_strap;
    logic autocfg_mosi = 1'b0, autocfg_done = 1'b0, spi_select_low_out, spi_select_low_oe_n;
    logic mosi_out, mosi_oe_n, test_mode, nvm_program_mode, autocfg_enable, autocfg_busy, bsy;
    logic [1:0] iface_straps, if_mode;
    logic [2:0] config_select_straps, config_number, test_mode_sel;
    logic [3:0] general_io_out = 4'h0, general_io_oe_n = 4'hF, general_io_pin_out, general_io_pin_oe_n;
    logic [5:0] strap_capture_status;
    logic [7:0] ident_reg_high, ident_reg_low;
    logic [6:0] i2c_addr_setting;
    rsc_straps_t res = 6'h00, pins, s;
    int seed = 54, fails = 0, checks = 0, cyc = 0;
    rsc_sampler dut (.*);
    rsc_board board (.strap_res(res), .gpio_out(general_io_pin_out),
        .gpio_oe_n(general_io_pin_oe_n), .sel_out(spi_select_low_out),
        .sel_oe_n(spi_select_low_oe_n), .pins(pins));
    assign {test_strap, iface_straps, config_select_straps} = pins;
    always #12.5 clock = ~clock;
    function automatic logic [1:0] exp_if(logic nvm, logic [1:0] f);
        return nvm ? {1'b0, &f} : {&f, f[1]};
    endfunction : exp_if
    task automatic cmp(string n, logic [15:0] e, logic [15:0] v);
        checks++;
        if (v !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, v);
        end
    endtask : cmp
    task conclude;
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task step(int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : step
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        step(8);
        resetn = 1'b1;
        cmp("ident", {`RSC_IDENT_VAL, `RSC_REV_VAL}, {ident_reg_high, ident_reg_low});
        for (int i = 0; i < 60; i++) begin
            res = $random(seed);
            internal_nvm = $random(seed);
            // Corners: programming mode, then the no-autoconfig start
            if (i < 2) res = i ? 6'h2B : 6'h38;
            if (i < 2) internal_nvm = !i;
            reset_pin_low = 1'b0;
            step(3);
            s = res;
            bsy = !s.test && !internal_nvm && s.iface == 2'h3;
            reset_pin_low = 1'b1;
            step(1);
            res = ~res;
            general_io_oe_n = $random(seed);
            general_io_out = $random(seed);
            autocfg_mosi = $random(seed);
            step(1);
            cmp("status", s, strap_capture_status);
            cmp("config", s.config_sel, config_number);
            cmp("if_mode", exp_if(internal_nvm, s.iface), if_mode);
            cmp("test", s.test, test_mode);
            cmp("autocfg", !s.test, autocfg_enable);
            cmp("nvm", internal_nvm && s == 6'h38, nvm_program_mode);
            cmp("busy", {bsy, !bsy}, {autocfg_busy, mosi_oe_n});
            cmp("mosi", bsy ? autocfg_mosi : 1'b1, mosi_out);
            cmp("test_sel", s.test ? s.config_sel : 3'h0, test_mode_sel);
            cmp("i2c", {`RSC_I2C_ADDR_BASE,
                ((exp_if(internal_nvm, s.iface) == 2'h0) ? s.iface : 2'h0)},
                i2c_addr_setting);
            cmp("gpio", {general_io_oe_n, general_io_out}, {general_io_pin_oe_n, general_io_pin_out});
            autocfg_done = 1'b1;
            step(1);
            autocfg_done = 1'b0;
            step(1);
            cmp("select", 1'b1, spi_select_low_oe_n);
        end
        conclude();
    end
endmodule : rsc_sampler_bench
`default_nettype wire
